// ---- hdl/mode1_rail_cfg_pkg.sv ----
package mode1_rail_cfg_pkg;
  localparam logic [7:0] BUTTON_BUCK_ADDR = 8'h27;
  localparam logic [7:0] LEVEL_EN_ADDR    = 8'h28;
  localparam logic [7:0] BUTTON_BUCK_RST  = 8'h4c;
  localparam logic [7:0] LEVEL_EN_RST     = 8'h4f;
  localparam int RSVD_BIT       = 7;
  localparam int BUTTON_BIT     = 6;
  localparam int OFFSET_BIT     = 5;
  localparam int CORE_EN_BIT    = 3;
  localparam int SYS_EN_BIT     = 2;
  localparam int AON_EN_BIT     = 1;
  localparam int SREG_EN_BIT    = 0;
  localparam logic [4:0] BUCK_CODE_MAX = 5'h18;
  localparam logic [3:0] AON_CODE_MAX  = 4'h8;
  localparam int BUCK_BASE_MV   = 1500;
  localparam int AON_BASE_MV    = 1700;
  localparam int STEP_MV        = 25;
  localparam int OFFSET_MV      = 1200;
  localparam logic [1:0] MODE0  = 2'h0;
  localparam logic [1:0] MODE1  = 2'h1;

  typedef struct packed {
    logic        core_buck_enable;
    logic        system_buck_enable;
    logic        always_on_regulator_enable;
    logic        system_regulator_enable;
    logic        system_buck_offset_select;
    logic [4:0]  system_buck_voltage_code;
    logic [3:0]  always_on_regulator_voltage_code;
    logic [11:0] system_buck_mv;
    logic [11:0] always_on_mv;
  } rail_cfg_s;
endpackage

// ---- hdl/mode1_rail_config_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
module mode1_rail_config_regs (
  // clock and reset
  input  wire logic                           mclk_in,
  input  wire logic                           rst_in,
  // register port from the target interface
  input  wire logic                           reg_wr_in,
  input  wire logic [7:0]                     reg_addr_in,
  input  wire logic [7:0]                     reg_wdata_in,
  output logic      [7:0]                     reg_rdata_out,
  // mode selection
  input  wire logic                           pin_mode_source_select_in,
  input  wire logic [1:0]                     mode_reg_bits_in,
  input  wire logic                           mode_select_pin_a_in,
  input  wire logic                           mode_select_pin_b_in,
  input  wire logic                           button_fall_in,
  output logic                                return_to_mode0_out,
  output logic      [1:0]                     active_mode_out,
  // rail controllers
  output mode1_rail_cfg_pkg::rail_cfg_s       rail_cfg_out
);
  logic [7:0] button_buck_r;
  logic [7:0] level_en_r;
  logic [7:0] rdata_nxt;
  logic [1:0] mode_nxt;
  logic       return_nxt;
  mode1_rail_cfg_pkg::rail_cfg_s cfg_nxt;

  // address decode shared by write strobes and read mux
  function automatic logic addr_is(input logic [7:0] addr,
                                   input logic [7:0] target);
    addr_is = (addr == target);
  endfunction

  // buck table saturates above its last code
  function automatic logic [4:0] clamp_buck(input logic [4:0] code);
    if (code > mode1_rail_cfg_pkg::BUCK_CODE_MAX) begin
      clamp_buck = mode1_rail_cfg_pkg::BUCK_CODE_MAX;
    end else begin
      clamp_buck = code;
    end
  endfunction

  // always-on table saturates above its last code
  function automatic logic [3:0] clamp_aon(input logic [3:0] code);
    if (code > mode1_rail_cfg_pkg::AON_CODE_MAX) begin
      clamp_aon = mode1_rail_cfg_pkg::AON_CODE_MAX;
    end else begin
      clamp_aon = code;
    end
  endfunction

  // base plus one step per code, plus optional offset
  function automatic logic [11:0] level_mv(input int         base,
                                           input logic [4:0] code,
                                           input logic       add_offset);
    int mv;
    mv = base + mode1_rail_cfg_pkg::STEP_MV * int'(code);
    if (add_offset) begin
      mv = mv + mode1_rail_cfg_pkg::OFFSET_MV;
    end
    level_mv = 12'(mv);
  endfunction

  wire        hit_a        = addr_is(reg_addr_in, mode1_rail_cfg_pkg::BUTTON_BUCK_ADDR);
  wire        hit_b        = addr_is(reg_addr_in, mode1_rail_cfg_pkg::LEVEL_EN_ADDR);
  wire        wr_a         = reg_wr_in && hit_a;
  wire        wr_b         = reg_wr_in && hit_b;
  wire [4:0]  buck_clamped = clamp_buck(button_buck_r[4:0]);
  wire [3:0]  aon_clamped  = clamp_aon(level_en_r[7:4]);
  wire        offset_on    = button_buck_r[mode1_rail_cfg_pkg::OFFSET_BIT];
  wire [11:0] buck_mv      = level_mv(mode1_rail_cfg_pkg::BUCK_BASE_MV, buck_clamped,
                                      offset_on);
  wire [11:0] aon_mv       = level_mv(mode1_rail_cfg_pkg::AON_BASE_MV, {1'b0, aon_clamped},
                                      1'b0);
  wire [1:0]  sel_mode     = pin_mode_source_select_in ?
                             {mode_select_pin_b_in, mode_select_pin_a_in} : mode_reg_bits_in;
  wire        in_mode1     = (sel_mode == mode1_rail_cfg_pkg::MODE1);
  wire        button_return = button_fall_in && !button_buck_r[mode1_rail_cfg_pkg::BUTTON_BIT]
                              && (sel_mode != mode1_rail_cfg_pkg::MODE0);

  assign mode_nxt   = sel_mode;
  assign return_nxt = button_return;
  assign rdata_nxt  = hit_a ? button_buck_r :
                      hit_b ? level_en_r : 8'h00;

  always_comb begin
    cfg_nxt = '0;
    if (in_mode1) begin
      cfg_nxt.core_buck_enable           = level_en_r[mode1_rail_cfg_pkg::CORE_EN_BIT];
      cfg_nxt.system_buck_enable         = level_en_r[mode1_rail_cfg_pkg::SYS_EN_BIT];
      cfg_nxt.always_on_regulator_enable = level_en_r[mode1_rail_cfg_pkg::AON_EN_BIT];
      cfg_nxt.system_regulator_enable    = level_en_r[mode1_rail_cfg_pkg::SREG_EN_BIT];
      cfg_nxt.system_buck_offset_select  = button_buck_r[mode1_rail_cfg_pkg::OFFSET_BIT];
      cfg_nxt.system_buck_voltage_code   = button_buck_r[4:0];
      cfg_nxt.always_on_regulator_voltage_code = level_en_r[7:4];
      cfg_nxt.system_buck_mv             = buck_mv;
      cfg_nxt.always_on_mv               = aon_mv;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      button_buck_r <= mode1_rail_cfg_pkg::BUTTON_BUCK_RST;
      level_en_r    <= mode1_rail_cfg_pkg::LEVEL_EN_RST;
    end else begin
      if (wr_a) begin
        button_buck_r <= reg_wdata_in;
      end
      if (wr_b) begin
        level_en_r <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      reg_rdata_out       <= 8'h00;
      active_mode_out     <= mode1_rail_cfg_pkg::MODE0;
      return_to_mode0_out <= 1'b0;
      rail_cfg_out        <= '0;
    end else begin
      reg_rdata_out       <= rdata_nxt;
      active_mode_out     <= mode_nxt;
      return_to_mode0_out <= return_nxt;
      rail_cfg_out        <= cfg_nxt;
    end
  end

  // register storage
  a_write_a_stores: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_a
    |=> button_buck_r == $past(reg_wdata_in))
    else $error("0x27 write not stored");

  a_write_b_stores: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_b
    |=> level_en_r == $past(reg_wdata_in))
    else $error("0x28 write not stored");

  a_rsvd_stored: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_a
    |=> button_buck_r[7] == $past(reg_wdata_in[7]))
    else $error("reserved bit not stored");

  a_hold_a_idle: assert property (@(posedge mclk_in) disable iff (rst_in)
    !wr_a
    |=> $stable(button_buck_r))
    else $error("0x27 changed without write");

  a_hold_b_idle: assert property (@(posedge mclk_in) disable iff (rst_in)
    !wr_b
    |=> $stable(level_en_r))
    else $error("0x28 changed without write");

  a_reset_regs: assert property (@(posedge mclk_in)
    rst_in
    |=> (button_buck_r == 8'h4c && level_en_r[7:4] == 4'h4))
    else $error("register reset value wrong");

  a_reset_enables: assert property (@(posedge mclk_in)
    rst_in
    |=> level_en_r[3:0] == 4'hf)
    else $error("rail enables not set by reset");

  // read port
  a_read_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    reg_addr_in == 8'h27
    |=> reg_rdata_out == $past(button_buck_r))
    else $error("0x27 read data wrong");

  a_read_b: assert property (@(posedge mclk_in) disable iff (rst_in)
    reg_addr_in == 8'h28
    |=> reg_rdata_out == $past(level_en_r))
    else $error("0x28 read data wrong");

  a_read_other: assert property (@(posedge mclk_in) disable iff (rst_in)
    (reg_addr_in != 8'h27 && reg_addr_in != 8'h28)
    |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");

  a_reset_rdata: assert property (@(posedge mclk_in)
    rst_in
    |=> reg_rdata_out == 8'h00)
    else $error("read data not cleared by reset");

  // button reaction
  a_button_return: assert property (@(posedge mclk_in) disable iff (rst_in)
    (button_fall_in && !button_buck_r[6] && sel_mode != 2'h0)
    |=> return_to_mode0_out)
    else $error("button edge did not return to mode 0");

  a_button_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
    (button_buck_r[6] || sel_mode == 2'h0)
    |=> !return_to_mode0_out)
    else $error("mode switch despite hold setting");

  a_button_reset: assert property (@(posedge mclk_in)
    rst_in
    |=> button_buck_r[6])
    else $error("button bit not set by reset");

  a_return_quiet: assert property (@(posedge mclk_in) disable iff (rst_in)
    !button_fall_in
    |=> !return_to_mode0_out)
    else $error("return request without button edge");

  a_no_return_mode0: assert property (@(posedge mclk_in) disable iff (rst_in)
    sel_mode == 2'h0
    |=> !return_to_mode0_out)
    else $error("return request while in mode 0");

  // system buck level
  a_buck_voltage: assert property (@(posedge mclk_in) disable iff (rst_in)
    (in_mode1 && button_buck_r[5:0] == 6'h2c)
    |=> rail_cfg_out.system_buck_mv == 12'd3000)
    else $error("buck offset voltage wrong");

  a_offset_zero: assert property (@(posedge mclk_in) disable iff (rst_in)
    (in_mode1 && button_buck_r[5:0] == 6'h0c)
    |=> rail_cfg_out.system_buck_mv == 12'd1800)
    else $error("buck level without offset wrong");

  a_offset_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
    in_mode1
    |=> rail_cfg_out.system_buck_offset_select == $past(button_buck_r[5]))
    else $error("buck offset flag wrong");

  a_buck_clamp: assert property (@(posedge mclk_in) disable iff (rst_in)
    in_mode1
    |=> rail_cfg_out.system_buck_mv <= 12'd3300)
    else $error("buck code not clamped");

  a_buck_floor: assert property (@(posedge mclk_in) disable iff (rst_in)
    in_mode1
    |=> rail_cfg_out.system_buck_mv >= 12'd1500)
    else $error("buck level below table");

  a_buck_top: assert property (@(posedge mclk_in) disable iff (rst_in)
    (in_mode1 && button_buck_r[5:0] == 6'h18)
    |=> rail_cfg_out.system_buck_mv == 12'd2100)
    else $error("buck top code wrong");

  a_buck_saturate: assert property (@(posedge mclk_in) disable iff (rst_in)
    (in_mode1 && button_buck_r[5] && button_buck_r[4:0] > 5'h18)
    |=> rail_cfg_out.system_buck_mv == 12'd3300)
    else $error("buck code above table not held");

  a_buck_code_raw: assert property (@(posedge mclk_in) disable iff (rst_in)
    in_mode1
    |=> rail_cfg_out.system_buck_voltage_code == $past(button_buck_r[4:0]))
    else $error("buck code not presented");

  // always-on regulator level
  a_aon_clamp: assert property (@(posedge mclk_in) disable iff (rst_in)
    in_mode1
    |=> (rail_cfg_out.always_on_mv <= 12'd1900 && rail_cfg_out.always_on_mv >= 12'd1700))
    else $error("regulator level out of range");

  a_aon_reset_level: assert property (@(posedge mclk_in) disable iff (rst_in)
    (in_mode1 && level_en_r[7:4] == 4'h4)
    |=> rail_cfg_out.always_on_mv == 12'd1800)
    else $error("regulator default level wrong");

  a_aon_saturate: assert property (@(posedge mclk_in) disable iff (rst_in)
    (in_mode1 && level_en_r[7:4] > 4'h8)
    |=> rail_cfg_out.always_on_mv == 12'd1900)
    else $error("regulator code above table not held");

  a_aon_code_raw: assert property (@(posedge mclk_in) disable iff (rst_in)
    in_mode1
    |=> rail_cfg_out.always_on_regulator_voltage_code == $past(level_en_r[7:4]))
    else $error("regulator code not presented");

  // rail enables
  a_core_enable: assert property (@(posedge mclk_in) disable iff (rst_in)
    in_mode1
    |=> rail_cfg_out.core_buck_enable == $past(level_en_r[3]))
    else $error("core buck enable wrong");

  a_sys_enable: assert property (@(posedge mclk_in) disable iff (rst_in)
    in_mode1
    |=> rail_cfg_out.system_buck_enable == $past(level_en_r[2]))
    else $error("system buck enable wrong");

  a_aon_enable: assert property (@(posedge mclk_in) disable iff (rst_in)
    in_mode1
    |=> rail_cfg_out.always_on_regulator_enable == $past(level_en_r[1]))
    else $error("always-on regulator enable wrong");

  a_sreg_enable: assert property (@(posedge mclk_in) disable iff (rst_in)
    in_mode1
    |=> rail_cfg_out.system_regulator_enable == $past(level_en_r[0]))
    else $error("system regulator enable wrong");

  // mode selection and presentation
  a_pin_source: assert property (@(posedge mclk_in) disable iff (rst_in)
    pin_mode_source_select_in
    |=> active_mode_out == $past({mode_select_pin_b_in, mode_select_pin_a_in}))
    else $error("pin mode source ignored");

  a_reg_source: assert property (@(posedge mclk_in) disable iff (rst_in)
    !pin_mode_source_select_in
    |=> active_mode_out == $past(mode_reg_bits_in))
    else $error("register mode source ignored");

  a_mode1_tracks: assert property (@(posedge mclk_in) disable iff (rst_in)
    in_mode1
    |=> active_mode_out == 2'h1)
    else $error("mode 1 not reported");

  a_outside_mode1: assert property (@(posedge mclk_in) disable iff (rst_in)
    !in_mode1
    |=> rail_cfg_out == '0)
    else $error("fields presented outside mode 1");

  a_reset_outputs: assert property (@(posedge mclk_in)
    rst_in
    |=> (rail_cfg_out == '0 && !return_to_mode0_out && active_mode_out == 2'h0))
    else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// ---- verif/mode1_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module mode1_host_model (
  input  wire logic       mclk_in,
  input  wire logic [7:0] rdata_in,
  output logic            wr_out,
  output logic      [7:0] addr_out,
  output logic      [7:0] data_out
);
  initial begin
    wr_out = 1'b0;
    addr_out = 8'h00;
    data_out = 8'h00;
  end
  // released lines show the inverse of the last value
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    addr_out = a;
    data_out = d;
    wr_out = 1'b1;
    @(posedge mclk_in);
    #1;
    wr_out = 1'b0;
    addr_out = ~a;
    data_out = ~d;
    @(posedge mclk_in);
    #1;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    addr_out = a;
    @(posedge mclk_in);
    #1;
    d = rdata_in;
    addr_out = ~a;
  endtask
endmodule
`default_nettype wire

// ---- verif/mode1_rail_config_regs_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module mode1_rail_config_regs_tb_top;
  logic                          mclk, rst, wr, psel, pa, pb, btn, ret;
  logic [7:0]                    addr, wd, rd, v;
  logic [1:0]                    mbits, am;
  mode1_rail_cfg_pkg::rail_cfg_s cfg;
  int                            failures = 0;
  int                            comparisons = 0;
  mode1_host_model mode1_host_model_inst (.mclk_in(mclk), .rdata_in(rd), .wr_out(wr),
    .addr_out(addr), .data_out(wd));
  mode1_rail_config_regs mode1_rail_config_regs_inst (.mclk_in(mclk), .rst_in(rst),
    .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_rdata_out(rd),
    .pin_mode_source_select_in(psel), .mode_reg_bits_in(mbits), .mode_select_pin_a_in(pa),
    .mode_select_pin_b_in(pb), .button_fall_in(btn), .return_to_mode0_out(ret),
    .active_mode_out(am), .rail_cfg_out(cfg));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  function automatic mode1_rail_cfg_pkg::rail_cfg_s exp_cfg(input logic [7:0] b, l);
    int bm;
    int lm;
    bm = 1500 + 25 * ((b[4:0] > 5'h18) ? 24 : b[4:0]) + (b[5] ? 1200 : 0);
    lm = 1700 + 25 * ((l[7:4] > 4'h8) ? 8 : l[7:4]);
    return {l[3:0], b[5:0], l[7:4], bm[11:0], lm[11:0]};
  endfunction
  task automatic chk(input logic [7:0] g, e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t byte got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_cfg(input mode1_rail_cfg_pkg::rail_cfg_s e);
    comparisons++;
    if (cfg !== e) begin
      failures++;
      $display("MISMATCH %0t rail cfg got %h exp %h", $time, cfg, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, d);
    mode1_host_model_inst.write(a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, e);
    mode1_host_model_inst.read(a, v);
    chk(v, e);
  endtask
  task automatic pulse(input logic e);
    btn = 1'b1;
    cyc(1);
    btn = 1'b0;
    chk({7'h00, ret}, {7'h00, e});
    cyc(1);
    chk({7'h00, ret}, 8'h00);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #(2000 * 100);
    failures++;
    end_of_test();
  end
  initial begin
    {rst, psel, pa, pb, btn} = 5'h10;
    mbits = 2'h1;
    cyc(10);
    rst = 1'b0;
    rd_chk(8'h27, 8'h4c);
    rd_chk(8'h28, 8'h4f);
    rd_chk(8'h29, 8'h00);
    chk({6'h00, am}, 8'h01);
    chk_cfg(exp_cfg(8'h4c, 8'h4f));
    pulse(1'b0);
    wr_reg(8'h27, 8'hb9);
    wr_reg(8'h28, 8'h9a);
    wr_reg(8'h2a, 8'hff);
    chk_cfg(exp_cfg(8'hb9, 8'h9a));
    rd_chk(8'h27, 8'hb9);
    rd_chk(8'h28, 8'h9a);
    wr_reg(8'h27, 8'h2c);
    chk_cfg(exp_cfg(8'h2c, 8'h9a));
    wr_reg(8'h27, 8'h18);
    wr_reg(8'h28, 8'h05);
    chk_cfg(exp_cfg(8'h18, 8'h05));
    pulse(1'b1);
    mbits = 2'h0;
    cyc(2);
    chk_cfg('0);
    pulse(1'b0);
    {psel, pa} = 2'h3;
    cyc(2);
    chk({6'h00, am}, 8'h01);
    {pa, pb} = 2'h1;
    cyc(2);
    chk({6'h00, am}, 8'h02);
    chk_cfg('0);
    rd_chk(8'h28, 8'h05);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    rd_chk(8'h27, 8'h4c);
    rd_chk(8'h28, 8'h4f);
    chk_cfg('0);
    end_of_test();
  end
endmodule
`default_nettype wire
